/* File: verilog/sesd_datapath.sv */
// Shift, extend, store, stack and branch-link execution datapath
// Functional notes
// - Zero shift length passes operand unchanged and keeps carry; nonzero updates carry.
// - Arithmetic right shift fills the top n bits with the original sign.
// - Flag-setting arithmetic right shift loads carry with source bit n-1.
// - Arithmetic shift of 32 or more gives all sign bits; carry is bit 31.
// - Logical right shift moves bits down and zeros the top n bits.
// - Return address written to the link register always has bit 0 set.
// - And-test sets only negative and zero flags and writes no register.
// - Zero-extend writes low halfword or byte, upper bits clear, flags untouched.
// - Store-multiple writes ascending words from base, then writes base back.
// - Halfword and byte stores write only the low bits, no flag change.
// - Stack-save stores below the stack pointer, lowering it four per register.
// - Stack-restore loads ascending, raises stack pointer; restoring counter branches when bit 0 is set, else faults.
// - Misaligned word or halfword access raises the fatal fault instead.
// - Each flag but overflow, which is never written, is set when its condition holds, cleared otherwise.
// - Logical shift of 32 or more gives zero; 33 or more clears carry.
`timescale 1ns/1ps
`include "sesd_defs.svh"
module sesd_datapath import sesd_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire sesd_instr_t instr,
  output logic instr_ready,
  output sesd_mem_t mem_o,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output sesd_flags_t flags_o,
  output sesd_branch_t branch_o,
  output logic fault_o
);
  logic [31:0] regs_r [`SESD_NREGS];
  sesd_state_t state_r;
  sesd_op_t op_r;
  sesd_flags_t flags_r;
  sesd_mem_t mem_r;
  sesd_branch_t branch_r;
  logic ready_r;
  logic fault_r;
  logic [15:0] list_r;
  logic [3:0] base_idx_r;
  logic [31:0] wb_val_r;

  logic fire;
  logic [31:0] src_a;
  logic [31:0] src_b;
  logic [7:0] sh_amt;
  logic [31:0] sh_res;
  logic sh_carry;
  logic sh_carry_upd;
  logic is_shift;
  logic is_list;
  logic is_store;
  logic is_mem;
  logic is_reg_branch;
  logic [31:0] ea;
  sesd_size_t ea_size;
  logic [31:0] st_data;
  logic misal;
  logic [31:0] fmt_wdata;
  logic issue_fault;
  logic [31:0] ret_addr;
  logic [31:0] test_and;
  logic [31:0] lst_bytes;
  logic [3:0] cur_idx;
  logic [15:0] list_rest;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [31:0] wr_data;
  logic last_out;

  assign instr_ready = ready_r;
  assign mem_o = mem_r;
  assign flags_o = flags_r;
  assign branch_o = branch_r;
  assign fault_o = fault_r;

  assign fire = instr_valid & ready_r;
  assign src_a = regs_r[instr.rn];
  assign src_b = regs_r[instr.rm];
  // Only the low byte counts, so lengths above 31 behave as full shifts
  assign sh_amt = instr.shift_by_reg ? src_b[`SESD_AMT_MSB:0] : instr.shamt;
  assign is_shift = (instr.op == OP_ARITH_SHIFT_RIGHT) | (instr.op == OP_LOGICAL_SHIFT_RIGHT);
  assign is_list = (instr.op == OP_STORE_MULTIPLE) | (instr.op == OP_PUSH) |
    (instr.op == OP_POP);
  assign is_store = (instr.op == OP_STR) | (instr.op == OP_STORE_HALF) |
    (instr.op == OP_STORE_BYTE);
  assign is_mem = is_list | is_store;
  assign is_reg_branch = (instr.op == OP_BRANCH_EXCHANGE) |
    (instr.op == OP_BRANCH_LINK_EXCHANGE);
  assign test_and = src_a & src_b;
  assign lst_bytes = sesd_list_bytes(instr.reglist);
  assign ret_addr = instr.iaddr +
    ((instr.op == OP_BRANCH_WITH_LINK) ? `SESD_LONG_INSN_BYTES : `SESD_INSN_BYTES);
  assign cur_idx = sesd_lowest(list_r);
  assign list_rest = list_r & (list_r - 16'h1);
  assign last_out = src_a[sh_amt[4:0] - 5'h1];

  sesd_shifter u_shifter (
    .src(src_a),
    .amt(sh_amt),
    .arith(instr.op == OP_ARITH_SHIFT_RIGHT),
    .res(sh_res),
    .carry(sh_carry),
    .carry_upd(sh_carry_upd)
  );

  always_comb begin
    ea_size = SZ_WORD;
    st_data = regs_r[instr.rd];
    case (instr.op)
      OP_STR: ea = src_a + instr.offset;
      OP_STORE_HALF: begin
        ea = src_a + instr.offset;
        ea_size = SZ_HALF;
      end
      OP_STORE_BYTE: begin
        ea = src_a + instr.offset;
        ea_size = SZ_BYTE;
      end
      OP_STORE_MULTIPLE: begin
        ea = src_a;
        st_data = regs_r[sesd_lowest(instr.reglist)];
      end
      OP_PUSH: begin
        ea = regs_r[`SESD_SP_IDX] - lst_bytes;
        st_data = regs_r[sesd_lowest(instr.reglist)];
      end
      default: ea = regs_r[`SESD_SP_IDX];
    endcase
  end

  sesd_store_fmt u_store_fmt (
    .addr(ea),
    .size(ea_size),
    .data(st_data),
    .misaligned(misal),
    .wdata(fmt_wdata)
  );

  // List ops stay word aligned once the base is, so one check covers them
  assign issue_fault = fire & ((is_mem & misal) | (is_reg_branch & ~src_b[`SESD_ISA_BIT]));

  // Single register write port; stack ops defer base writeback to ST_WB
  always_comb begin
    wr_en = 1'b0;
    wr_idx = instr.rd;
    wr_data = sh_res;
    if (fire && !issue_fault) begin
      case (instr.op)
        OP_ARITH_SHIFT_RIGHT, OP_LOGICAL_SHIFT_RIGHT: wr_en = 1'b1;
        OP_ZERO_EXT_HALF: begin
          wr_en = 1'b1;
          wr_data = {16'h0, src_b[`SESD_HALF_MSB:0]};
        end
        OP_ZERO_EXT_BYTE: begin
          wr_en = 1'b1;
          wr_data = {24'h0, src_b[`SESD_BYTE_MSB:0]};
        end
        OP_BRANCH_WITH_LINK, OP_BRANCH_LINK_EXCHANGE: begin
          wr_en = 1'b1;
          wr_idx = `SESD_LINK_IDX;
          wr_data = ret_addr | 32'h1;
        end
        default: wr_en = 1'b0;
      endcase
    end else if (state_r == ST_MEM && mem_ack && op_r == OP_POP &&
                 cur_idx != `SESD_COUNTER_IDX) begin
      wr_en = 1'b1;
      wr_idx = cur_idx;
      wr_data = mem_rdata;
    end else if (state_r == ST_WB) begin
      wr_en = 1'b1;
      wr_idx = base_idx_r;
      wr_data = wb_val_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < `SESD_NREGS; k++) begin
        regs_r[k] <= `SESD_REG_RESET;
      end
    end else if (wr_en) begin
      regs_r[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else if (fire && !issue_fault) begin
      if (is_shift && instr.set_flags) begin
        flags_r.n <= sh_res[`SESD_SIGN_BIT];
        flags_r.z <= (sh_res == 32'h0);
        if (sh_carry_upd) begin
          flags_r.c <= sh_carry;
        end
      end else if (instr.op == OP_AND_TEST) begin
        flags_r.n <= test_and[`SESD_SIGN_BIT];
        flags_r.z <= (test_and == 32'h0);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      branch_r <= '0;
      fault_r <= 1'b0;
    end else begin
      branch_r.valid <= 1'b0;
      fault_r <= issue_fault;
      if (fire && !issue_fault && (is_reg_branch || instr.op == OP_BRANCH_WITH_LINK)) begin
        branch_r.valid <= 1'b1;
        branch_r.target <= (instr.op == OP_BRANCH_WITH_LINK) ? instr.offset : src_b & ~32'h1;
      end else if (state_r == ST_MEM && mem_ack && op_r == OP_POP &&
                   cur_idx == `SESD_COUNTER_IDX) begin
        if (mem_rdata[`SESD_ISA_BIT]) begin
          branch_r.valid <= 1'b1;
          branch_r.target <= mem_rdata & ~32'h1;
        end else begin
          fault_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b1;
      op_r <= OP_NOP;
      mem_r <= '0;
      list_r <= 16'h0;
      base_idx_r <= `SESD_SP_IDX;
      wb_val_r <= `SESD_REG_RESET;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (fire && !issue_fault && is_store) begin
            op_r <= instr.op;
            list_r <= 16'h0;
            mem_r <= '{req: 1'b1, we: 1'b1, size: ea_size, addr: ea, wdata: fmt_wdata};
            ready_r <= 1'b0;
            state_r <= ST_MEM;
          end else if (fire && !issue_fault && is_list && instr.reglist != 16'h0) begin
            op_r <= instr.op;
            list_r <= instr.reglist;
            base_idx_r <= (instr.op == OP_STORE_MULTIPLE) ? instr.rn : `SESD_SP_IDX;
            case (instr.op)
              OP_STORE_MULTIPLE: wb_val_r <= src_a + lst_bytes;
              OP_PUSH: wb_val_r <= ea;
              default: wb_val_r <= ea + lst_bytes;
            endcase
            mem_r <= '{req: 1'b1, we: (instr.op != OP_POP), size: SZ_WORD,
                       addr: ea, wdata: st_data};
            ready_r <= 1'b0;
            state_r <= ST_MEM;
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            list_r <= list_rest;
            if (list_rest != 16'h0) begin
              mem_r.addr <= mem_r.addr + `SESD_WORD_BYTES;
              mem_r.wdata <= regs_r[sesd_lowest(list_rest)];
            end else begin
              mem_r.req <= 1'b0;
              if (list_r == 16'h0) begin
                ready_r <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                state_r <= ST_WB;
              end
            end
          end
        end
        ST_WB: begin
          ready_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          mem_r.req <= 1'b0;
          ready_r <= 1'b1;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_zero_shift_carry: assert property (
    fire && is_shift && instr.set_flags && sh_amt == 8'h0
    |=> flags_r.c == $past(flags_r.c) && regs_r[$past(instr.rd)] == $past(src_a))
    else $error("zero shift altered carry or value");

  a_arith_sign_fill: assert property (
    fire && instr.op == OP_ARITH_SHIFT_RIGHT && sh_amt != 8'h0 && sh_amt < `SESD_FULL_SHIFT
    |-> sh_res[31] == src_a[31] && sh_res[0] == src_a[sh_amt[4:0]])
    else $error("arithmetic shift lost sign or misplaced bits");

  a_arith_carry_last: assert property (
    fire && !issue_fault && instr.op == OP_ARITH_SHIFT_RIGHT && instr.set_flags &&
    sh_amt != 8'h0 && sh_amt < `SESD_FULL_SHIFT
    |=> flags_r.c == $past(last_out))
    else $error("arithmetic shift carry is not last bit out");

  a_arith_wide_sign: assert property (
    fire && instr.op == OP_ARITH_SHIFT_RIGHT && sh_amt >= `SESD_FULL_SHIFT
    |-> sh_res == {32{src_a[31]}} && sh_carry == src_a[31])
    else $error("wide arithmetic shift wrong");

  a_logical_top_zero: assert property (
    fire && instr.op == OP_LOGICAL_SHIFT_RIGHT && sh_amt != 8'h0 && sh_amt < `SESD_FULL_SHIFT
    |-> !sh_res[31] && sh_res[0] == src_a[sh_amt[4:0]])
    else $error("logical shift top bits not zero");

  a_logical_wide_zero: assert property (
    fire && instr.op == OP_LOGICAL_SHIFT_RIGHT && sh_amt > `SESD_FULL_SHIFT
    |-> sh_res == 32'h0 && !sh_carry)
    else $error("wide logical shift not zero");

  a_link_bit_set: assert property (
    fire && !issue_fault &&
    (instr.op == OP_BRANCH_WITH_LINK || instr.op == OP_BRANCH_LINK_EXCHANGE)
    |=> regs_r[`SESD_LINK_IDX] == ($past(ret_addr) | 32'h1) && branch_o.valid)
    else $error("link register return address wrong");

  a_branch_mode_bit: assert property (
    fire && is_reg_branch && !src_b[0] |=> fault_o && !branch_o.valid)
    else $error("branch with clear mode bit not faulted");

  a_test_flags: assert property (
    fire && instr.op == OP_AND_TEST |-> !wr_en ##1
    flags_r.z == ($past(test_and) == 32'h0) && flags_r.c == $past(flags_r.c))
    else $error("and-test flags or write wrong");

  a_uxt_clear: assert property (
    fire && instr.op == OP_ZERO_EXT_BYTE |-> wr_en && wr_data[31:8] == 24'h0
    ##1 flags_r == $past(flags_r))
    else $error("zero-extend wrong");

  a_byte_store: assert property (
    fire && !issue_fault && instr.op == OP_STORE_BYTE
    |=> mem_o.req && mem_o.we && mem_o.size == SZ_BYTE && mem_o.wdata[31:8] == 24'h0)
    else $error("byte store drives upper bits");

  a_list_ascend: assert property (
    state_r == ST_MEM && mem_ack && list_rest != 16'h0
    |=> mem_o.req && mem_o.addr == $past(mem_o.addr) + `SESD_WORD_BYTES)
    else $error("list access not ascending");

  a_misalign_fault: assert property (
    fire && is_mem && misal |=> fault_o && !mem_o.req && instr_ready)
    else $error("misaligned access not faulted");

  c_arith_wide: cover property (fire && instr.op == OP_ARITH_SHIFT_RIGHT &&
    sh_amt >= `SESD_FULL_SHIFT);
  c_push_done: cover property (state_r == ST_WB && op_r == OP_PUSH);
  c_pop_branch: cover property (branch_o.valid && op_r == OP_POP);
  c_fault: cover property (fault_o);
endmodule // sesd_datapath

/* File: shared/sesd_defs.svh */
// Shared numeric constants for the shift, extend and store datapath
`ifndef SESD_DEFS_SVH
`define SESD_DEFS_SVH
`define SESD_XLEN 32
`define SESD_NREGS 16
`define SESD_SP_IDX 4'hd
`define SESD_LINK_IDX 4'he
`define SESD_COUNTER_IDX 4'hf
`define SESD_WORD_BYTES 32'h4
`define SESD_INSN_BYTES 32'h2
`define SESD_LONG_INSN_BYTES 32'h4
`define SESD_REG_RESET 32'h0
`define SESD_FULL_SHIFT 8'h20
`define SESD_SIGN_BIT 31
`define SESD_ISA_BIT 0
`define SESD_HALF_MSB 15
`define SESD_BYTE_MSB 7
`define SESD_AMT_MSB 7
`endif

/* File: shared/sesd_pkg.sv */
// Types and list helpers for the shift, extend and store datapath
`include "sesd_defs.svh"
package sesd_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ARITH_SHIFT_RIGHT = 4'h1, OP_LOGICAL_SHIFT_RIGHT = 4'h2,
    OP_AND_TEST = 4'h3, OP_ZERO_EXT_HALF = 4'h4, OP_ZERO_EXT_BYTE = 4'h5, OP_STR = 4'h6,
    OP_STORE_HALF = 4'h7, OP_STORE_BYTE = 4'h8, OP_STORE_MULTIPLE = 4'h9, OP_PUSH = 4'ha,
    OP_POP = 4'hb, OP_BRANCH_EXCHANGE = 4'hc, OP_BRANCH_LINK_EXCHANGE = 4'hd,
    OP_BRANCH_WITH_LINK = 4'he
  } sesd_op_t;

  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} sesd_size_t;

  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_MEM = 3'b010, ST_WB = 3'b100} sesd_state_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } sesd_flags_t;

  typedef struct packed {
    sesd_op_t op;
    logic [3:0] rd;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [15:0] reglist;
    logic [7:0] shamt;
    logic shift_by_reg;
    logic set_flags;
    logic [31:0] offset;
    logic [31:0] iaddr;
  } sesd_instr_t;

  typedef struct packed {
    logic req;
    logic we;
    sesd_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sesd_mem_t;

  typedef struct packed {
    logic valid;
    logic [31:0] target;
  } sesd_branch_t;

  function automatic logic [4:0] sesd_popcount(input logic [15:0] l);
    logic [4:0] c;
    c = 5'h0;
    for (int k = 0; k < 16; k++) begin
      c = c + {4'h0, l[k]};
    end
    return c;
  endfunction

  function automatic logic [3:0] sesd_lowest(input logic [15:0] l);
    logic [3:0] i;
    i = 4'h0;
    for (int k = 15; k >= 0; k--) begin
      if (l[k]) begin
        i = 4'(k);
      end
    end
    return i;
  endfunction

  function automatic logic [31:0] sesd_list_bytes(input logic [15:0] l);
    return {25'h0, sesd_popcount(l), 2'b00};
  endfunction
endpackage

/* File: verilog/sesd_shifter.sv */
// Right shifter with carry-out for arithmetic and logical shifts
`timescale 1ns/1ps
`include "sesd_defs.svh"
module sesd_shifter import sesd_pkg::*; (
  input wire logic [31:0] src,
  input wire logic [7:0] amt,
  input wire logic arith,
  output logic [31:0] res,
  output logic carry,
  output logic carry_upd
);
  always_comb begin
    res = src;
    carry = 1'b0;
    carry_upd = (amt != 8'h0);
    if (amt == 8'h0) begin
      res = src;
    end else if (amt >= `SESD_FULL_SHIFT) begin
      res = arith ? {`SESD_XLEN{src[`SESD_SIGN_BIT]}} : 32'h0;
      if (arith) begin
        carry = src[`SESD_SIGN_BIT];
      end else begin
        // Exactly 32 still shifts out bit 31; beyond that only zeros leave
        carry = (amt == `SESD_FULL_SHIFT) & src[`SESD_SIGN_BIT];
      end
    end else begin
      if (arith) begin
        res = 32'($signed(src) >>> amt[4:0]);
      end else begin
        res = src >> amt[4:0];
      end
      carry = src[amt[4:0] - 5'h1];
    end
  end
endmodule // sesd_shifter

/* File: verilog/sesd_store_fmt.sv */
// Store data formatting and alignment check
`timescale 1ns/1ps
`include "sesd_defs.svh"
module sesd_store_fmt import sesd_pkg::*; (
  input wire logic [31:0] addr,
  input wire sesd_size_t size,
  input wire logic [31:0] data,
  output logic misaligned,
  output logic [31:0] wdata
);
  always_comb begin
    case (size)
      SZ_WORD: begin
        misaligned = |addr[1:0];
        wdata = data;
      end
      SZ_HALF: begin
        misaligned = addr[0];
        wdata = {16'h0, data[`SESD_HALF_MSB:0]};
      end
      default: begin
        misaligned = 1'b0;
        wdata = {24'h0, data[`SESD_BYTE_MSB:0]};
      end
    endcase
  end
endmodule // sesd_store_fmt

/* File: testbench/sesd_mem_model.sv */
// Memory responder on the far side of the datapath's store and load bus
`timescale 1ns/1ps
module sesd_mem_model import sesd_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire sesd_mem_t mem_i,
  input wire logic slow,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [logic [29:0]];
  logic [1:0] wait_r;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r <= 2'h0;
    end else if (mem_ack || !mem_i.req) begin
      // Ack lasts one cycle so a held request for the next word is not double counted
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r <= slow ? 2'h3 : 2'h0;
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      if (mem_i.we) begin
        mem[mem_i.addr[31:2]] = mem_i.wdata;
      end else begin
        mem_rdata <= mem.exists(mem_i.addr[31:2]) ? mem[mem_i.addr[31:2]] : ~mem_i.addr;
      end
    end
  end
endmodule // sesd_mem_model

/* File: testbench/test_shift_extend_store_datapath.sv */
// Self-checking bench for the shift, extend and store datapath
`timescale 1ns/1ps
module test_shift_extend_store_datapath;
  import sesd_pkg::*;
  typedef struct {
    logic [1:0] kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
    sesd_size_t sz;
  } sesd_exp_t;
  logic mclk, rst_n, instr_valid, instr_ready, mem_ack, fault_o, slow, sf, br, ar;
  sesd_instr_t instr;
  sesd_mem_t mem_o;
  logic [31:0] mem_rdata, a, ma, md;
  sesd_flags_t flags_o, ef;
  sesd_branch_t branch_o;
  sesd_exp_t e;
  sesd_exp_t q [$];
  logic [31:0] rg [16];
  logic [32:0] res;
  logic [3:0] rd, rn, rm;
  logic [7:0] n;
  logic [7:0] am [8] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'hc8, 8'h10, 8'h05};
  logic [1:0] mk;
  sesd_size_t ms;
  int fails, compares, cyc, seed, i;

  sesd_datapath u_dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .flags_o(flags_o), .branch_o(branch_o), .fault_o(fault_o));
  sesd_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .mem_i(mem_o), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  // Bit-serial model of the right shifter; returns {carry, result}
  function automatic logic [32:0] shf(input logic [31:0] v, input logic [7:0] k,
      input logic sar, input logic c);
    logic [31:0] r;
    logic co;
    r = v;
    co = c;
    for (int j = 0; j < int'(k); j++) begin
      co = r[0];
      r = {sar & r[31], r[31:1]};
    end
    return {co, r};
  endfunction

  task automatic issue(input sesd_op_t op, input logic [3:0] d, input logic [3:0] s,
      input logic [3:0] m, input logic [15:0] rl, input logic [7:0] sh, input logic b,
      input logic [31:0] off);
    int w;
    w = 0;
    while (instr_ready !== 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
    instr_valid = 1'b1;
    instr = '{op, d, s, m, rl, sh, b, sf, off, 32'h0000_1000};
    @(negedge mclk);
    instr_valid = 1'b0;
    w = 0;
    while (instr_ready !== 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
  endtask

  task automatic expect_ev(input logic [1:0] k, input logic [31:0] ad, input logic [31:0] d,
      input logic [31:0] m, input sesd_size_t z);
    q.push_back('{k, ad, d, m, z});
  endtask

  // Store through r12, which stays zero, so the offset is the address
  task automatic st(input sesd_op_t op, input logic [3:0] r, input logic [31:0] ad,
      input logic [31:0] m, input sesd_size_t z, input logic [1:0] k);
    expect_ev(k, ad, rg[r], m, z);
    issue(op, r, 4'hc, 4'h0, 16'h0, 8'h0, 1'b0, ad);
  endtask

  // Results are taken off the queue in the order they appear at the outputs
  always @(posedge mclk) begin
    if (rst_n && ((mem_o.req && mem_o.we && mem_ack) || branch_o.valid || fault_o)) begin
      if (q.size() == 0) begin
        fails++;
        $display("mismatch at %0t: result with nothing expected", $time);
      end else begin
        e = q.pop_front();
        ma = e.addr;
        md = e.data & e.mask;
        ms = e.sz;
        mk = 2'h2;
        if (mem_o.req && mem_o.we && mem_ack) begin
          mk = 2'h0;
          ma = mem_o.addr;
          md = mem_o.wdata & e.mask;
          ms = mem_o.size;
        end else if (branch_o.valid) begin
          mk = 2'h1;
          ma = branch_o.target;
        end
        compares++;
        if (mk !== e.kind || ma !== e.addr || md !== (e.data & e.mask) || ms !== e.sz) begin
          fails++;
          $display("mismatch at %0t: kind %0d addr %h data %h want %0d %h %h", $time,
            mk, ma, md, e.kind, e.addr, e.data & e.mask);
        end
      end
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  initial begin
    instr_valid = 1'b0;
    instr = '0;
    rst_n = 1'b0;
    slow = 1'b0;
    sf = 1'b1;
    ef = '0;
    fails = 0;
    compares = 0;
    cyc = 0;
    seed = 22;
    for (i = 0; i < 16; i++) rg[i] = 32'h0;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    chk32({28'h0, instr_ready, mem_o.req, branch_o.valid, fault_o}, 32'h8, "reset outputs");
    chk32(32'(flags_o), 32'h0, "reset flags");
    rst_n = 1'b1;
    // Load r0..r11 from memory; r9 odd and r10 even serve as branch targets
    for (i = 0; i < 12; i++) begin
      rg[i] = $random(seed);
      if (i == 9) rg[i][0] = 1'b1;
      if (i == 10) rg[i][0] = 1'b0;
      if (i == 11) rg[i] = 32'h0000_0200;
      u_mem.mem[30'(i)] = rg[i];
    end
    issue(OP_POP, 4'h0, 4'h0, 4'h0, 16'h0fff, 8'h0, 1'b0, 32'h0);
    rg[13] = 32'h0000_0030;
    for (i = 0; i < 16; i++) begin
      rd = 4'($unsigned($random(seed)) % 9);
      rn = 4'($unsigned($random(seed)) % 12);
      rm = 4'($unsigned($random(seed)) % 12);
      br = i[0];
      ar = i[1];
      sf = (i % 5 != 4);
      n = br ? rg[rm][7:0] : am[i % 8];
      res = shf(rg[rn], n, ar, ef.c);
      issue(ar ? OP_ARITH_SHIFT_RIGHT : OP_LOGICAL_SHIFT_RIGHT, rd, rn, rm, 16'h0,
        am[i % 8], br, 32'h0);
      if (sf) begin
        ef.c = res[32];
        ef.n = res[31];
        ef.z = (res[31:0] == 32'h0);
      end
      rg[rd] = res[31:0];
      chk32(32'(flags_o), 32'(ef), "shift flags");
      st(OP_STR, rd, 32'h100 + 32'(i * 4), 32'hffff_ffff, SZ_WORD, 2'h0);
    end
    sf = 1'b1;
    a = rg[3] & rg[4];
    issue(OP_AND_TEST, 4'h1, 4'h3, 4'h4, 16'h0, 8'h0, 1'b0, 32'h0);
    ef.n = a[31];
    ef.z = (a == 32'h0);
    chk32(32'(flags_o), 32'(ef), "test flags");
    st(OP_STR, 4'h1, 32'h0000_0180, 32'hffff_ffff, SZ_WORD, 2'h0);
    issue(OP_ZERO_EXT_HALF, 4'h5, 4'h0, 4'h6, 16'h0, 8'h0, 1'b0, 32'h0);
    rg[5] = {16'h0, rg[6][15:0]};
    issue(OP_ZERO_EXT_BYTE, 4'h7, 4'h0, 4'h8, 16'h0, 8'h0, 1'b0, 32'h0);
    rg[7] = {24'h0, rg[8][7:0]};
    chk32(32'(flags_o), 32'(ef), "extend flags");
    st(OP_STR, 4'h5, 32'h0000_0184, 32'hffff_ffff, SZ_WORD, 2'h0);
    st(OP_STR, 4'h7, 32'h0000_0188, 32'hffff_ffff, SZ_WORD, 2'h0);
    st(OP_STORE_HALF, 4'h2, 32'h0000_01c0, 32'h0000_ffff, SZ_HALF, 2'h0);
    st(OP_STORE_BYTE, 4'h3, 32'h0000_01c4, 32'h0000_00ff, SZ_BYTE, 2'h0);
    st(OP_STORE_BYTE, 4'h3, 32'h0000_01c9, 32'h0, SZ_BYTE, 2'h0);
    st(OP_STR, 4'h0, 32'h0000_01d2, 32'h0, SZ_WORD, 2'h2);
    st(OP_STORE_HALF, 4'h0, 32'h0000_01d5, 32'h0, SZ_WORD, 2'h2);
    chk32(32'(flags_o), 32'(ef), "store flags");
    // Slow memory stretches the store-multiple and push transfers; the pops run at full speed
    slow = 1'b1;
    expect_ev(2'h0, 32'h0000_0200, rg[1], 32'hffff_ffff, SZ_WORD);
    expect_ev(2'h0, 32'h0000_0204, rg[3], 32'hffff_ffff, SZ_WORD);
    expect_ev(2'h0, 32'h0000_0208, rg[5], 32'hffff_ffff, SZ_WORD);
    issue(OP_STORE_MULTIPLE, 4'h0, 4'hb, 4'h0, 16'h002a, 8'h0, 1'b0, 32'h0);
    rg[11] = 32'h0000_020c;
    issue(OP_STORE_MULTIPLE, 4'h0, 4'hb, 4'h0, 16'h0000, 8'h0, 1'b0, 32'h0);
    st(OP_STR, 4'hb, 32'h0000_0190, 32'hffff_ffff, SZ_WORD, 2'h0);
    for (i = 0; i < 3; i++) expect_ev(2'h0, 32'h24 + 32'(i * 4), rg[i], 32'hffff_ffff, SZ_WORD);
    issue(OP_PUSH, 4'h0, 4'h0, 4'h0, 16'h0007, 8'h0, 1'b0, 32'h0);
    rg[13] = 32'h0000_0024;
    st(OP_STR, 4'hd, 32'h0000_0194, 32'hffff_ffff, SZ_WORD, 2'h0);
    slow = 1'b0;
    expect_ev(2'h1, 32'h0000_4000, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_BRANCH_WITH_LINK, 4'h0, 4'h0, 4'h0, 16'h0, 8'h0, 1'b0, 32'h0000_4000);
    rg[14] = 32'h0000_1005;
    st(OP_STR, 4'he, 32'h0000_0198, 32'hffff_ffff, SZ_WORD, 2'h0);
    expect_ev(2'h1, rg[9] & 32'hffff_fffe, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_BRANCH_LINK_EXCHANGE, 4'h0, 4'h0, 4'h9, 16'h0, 8'h0, 1'b0, 32'h0);
    rg[14] = 32'h0000_1003;
    st(OP_STR, 4'he, 32'h0000_019c, 32'hffff_ffff, SZ_WORD, 2'h0);
    expect_ev(2'h1, rg[9] & 32'hffff_fffe, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_BRANCH_EXCHANGE, 4'h0, 4'h0, 4'h9, 16'h0, 8'h0, 1'b0, 32'h0);
    expect_ev(2'h2, 32'h0, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_BRANCH_EXCHANGE, 4'h0, 4'h0, 4'ha, 16'h0, 8'h0, 1'b0, 32'h0);
    u_mem.mem[30'h9] = 32'h0000_3001;
    expect_ev(2'h1, 32'h0000_3000, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_POP, 4'h0, 4'h0, 4'h0, 16'h8000, 8'h0, 1'b0, 32'h0);
    rg[13] = 32'h0000_0028;
    st(OP_STR, 4'hd, 32'h0000_01a0, 32'hffff_ffff, SZ_WORD, 2'h0);
    u_mem.mem[30'ha] = 32'h0000_3000;
    expect_ev(2'h2, 32'h0, 32'h0, 32'h0, SZ_BYTE);
    issue(OP_POP, 4'h0, 4'h0, 4'h0, 16'h8000, 8'h0, 1'b0, 32'h0);
    repeat (10) @(negedge mclk);
    chk32(32'(q.size()), 32'h0, "results still expected");
    final_report();
  end
endmodule // test_shift_extend_store_datapath
